// ### shared/branch_pkg.sv
package branch_pkg;

	localparam int WORD_W      = 16;
	localparam int DISP_W      = 5;
	localparam int COND_W      = 6;
	localparam int FBK_SEL_W   = 4;
	localparam int JUMP_REGS   = 2;
	localparam int PC_W_DEF    = 10;

	// Field positions inside the instruction word
	localparam int DISP_LSB      = 0;
	localparam int FBK_SEL_LSB   = 5;
	localparam int FBK_POL_BIT   = 9;
	localparam int FAR_SEL_BIT   = 3;
	localparam int CFAR_SEL_BIT  = 4;
	localparam int COND_LSB      = 5;

	// Opcode patterns and the bit ranges they cover
	localparam int             FBKR_LSB     = 10;
	localparam logic [5:0]     FBKR_OP      = 6'h05;
	localparam int             FAR_HI_LSB   = 4;
	localparam logic [11:0]    FAR_HI_OP    = 12'h39A;
	localparam logic [2:0]     FAR_LO_OP    = 3'h5;
	localparam int             REL_LSB      = 5;
	localparam logic [10:0]    REL_OP       = 11'h178;
	localparam int             CFAR_LSB     = 11;
	localparam logic [4:0]     CFAR_HI_OP   = 5'h07;
	localparam logic [3:0]     CFAR_LO_OP   = 4'h0;

	// Counts of flags, terminal counts and feedback sources
	localparam int FLAG_N    = 16;
	localparam int TC_N      = 4;
	localparam int SC_N      = 3;
	localparam int HI_DRV_N  = 5;
	localparam int LO_DRV_N  = 6;
	localparam int CUR_N     = 6;
	localparam int PIN_N     = 2 * HI_DRV_N + LO_DRV_N + 2 * SC_N + CUR_N + 3;

	localparam int PC_STEP   = 1;

	typedef enum logic [2:0] {
		BR_NONE,
		BR_FBK_REL,
		BR_FAR,
		BR_REL,
		BR_COND_FAR
	} branch_kind_t;

endpackage : branch_pkg

// ### src/branch_cond_eval.sv
`timescale 1ns/100ps
`default_nettype none

module branch_cond_eval
	import branch_pkg::*;
(
	input  wire logic [FLAG_N-1:0]    flags,
	input  wire logic [TC_N-1:0]      terminal_count,
	input  wire logic                 start_level,
	input  wire logic [SC_N-1:0]      shortcut_drain_fb,
	input  wire logic [SC_N-1:0]      shortcut_source_fb,
	input  wire logic                 alu_done,
	input  wire logic                 boost_voltage_high,
	input  wire logic [CUR_N-1:0]     current_fb,
	input  wire logic                 own_current_fb,
	input  wire logic [HI_DRV_N-1:0]  hi_drv_drain_fb,
	input  wire logic [HI_DRV_N-1:0]  hi_drv_source_fb,
	input  wire logic [LO_DRV_N-1:0]  lo_drv_drain_fb,
	input  wire logic [COND_W-1:0]    cond_code,
	input  wire logic [FBK_SEL_W-1:0] feedback_selector,
	input  wire logic                 feedback_polarity,
	output logic                      cond_met,
	output logic                      fbk_met
);

	logic [(1<<COND_W)-1:0]    cond_vec;
	logic [(1<<FBK_SEL_W)-1:0] fbk_vec;

	// Condition table, lowest code in the lowest bit
	assign cond_vec = {~own_current_fb, own_current_fb,               // RL14
	                   ~current_fb, current_fb,                       // RL13
	                   ~boost_voltage_high, boost_voltage_high,       // RL12
	                   alu_done,                                      // RL12
	                   shortcut_drain_fb, ~shortcut_source_fb,        // RL11
	                   ~shortcut_drain_fb,                            // RL11
	                   start_level, ~start_level,                     // RL10
	                   terminal_count, flags, ~flags};                // RL10
	assign cond_met = cond_vec[cond_code];

	// High side drain and source feedbacks interleave, low side follow
	genvar g;
	generate
		for (g = 0; g < HI_DRV_N; g++) begin : g_hi
			assign fbk_vec[2*g]   = hi_drv_drain_fb[g];               // RL4
			assign fbk_vec[2*g+1] = hi_drv_source_fb[g];              // RL4
		end
		for (g = 0; g < LO_DRV_N; g++) begin : g_lo
			assign fbk_vec[2*HI_DRV_N+g] = lo_drv_drain_fb[g];        // RL4
		end
	endgenerate

	assign fbk_met = (fbk_vec[feedback_selector] == feedback_polarity); // RL5

endmodule : branch_cond_eval

`default_nettype wire

// ### src/microcore_branch_decode.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RL1 - Relative target is own address plus displacement
// RL2 - Displacement is five-bit two's complement
// RL3 - Feedback relative jump taken on polarity match
// RL4 - Selector picks high-side pairs, then low-side drains
// RL5 - Polarity zero wants low, one wants high
// RL6 - Unconditional far jump loads selected jump register
// RL7 - Unconditional relative jump always branches
// RL8 - Conditional far jump loads only when condition holds
// RL9 - Register selector chooses the jump register
// RL10 - Codes cover flags, terminal counts, start
// RL11 - Codes cover shortcut drain and source feedbacks
// RL12 - Codes cover ALU done and boost voltage
// RL13 - Codes cover six current feedbacks high/low
// RL14 - Codes cover own current feedback high/low
// RL15 - Unmet condition steps to next location
// RL16 - Polarity bit 9, selector 8..5, displacement 4..0
module microcore_branch_decode
	import branch_pkg::*;
#(
	parameter int PC_W = PC_W_DEF
)(
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	input  wire logic                            instr_valid,
	input  wire logic [WORD_W-1:0]               instr_word,
	input  wire logic [PC_W-1:0]                 instr_addr,
	input  wire logic [JUMP_REGS-1:0][PC_W-1:0]  jump_register_set,
	input  wire logic [FLAG_N-1:0]               flags,
	input  wire logic [TC_N-1:0]                 terminal_count,
	input  wire logic                            alu_done,
	input  wire logic                            start_in,
	input  wire logic [SC_N-1:0]                 shortcut_drain_fb,
	input  wire logic [SC_N-1:0]                 shortcut_source_fb,
	input  wire logic                            boost_voltage_high,
	input  wire logic [CUR_N-1:0]                current_fb,
	input  wire logic                            own_current_fb,
	input  wire logic [HI_DRV_N-1:0]             hi_drv_drain_fb,
	input  wire logic [HI_DRV_N-1:0]             hi_drv_source_fb,
	input  wire logic [LO_DRV_N-1:0]             lo_drv_drain_fb,
	output logic      [PC_W-1:0]                 program_counter,
	output logic                                 pc_valid,
	output logic                                 branch_taken,
	output branch_kind_t                         branch_kind
);

	// Refuse program counter widths below the displacement width or above the word width
	if (PC_W < DISP_W || PC_W > WORD_W) begin : g_bad_pc_w
		$error("PC_W must lie between the displacement and word widths");
	end

	function automatic logic [PC_W-1:0] rel_target(
		input logic [PC_W-1:0]   base,
		input logic [DISP_W-1:0] disp
	);
		logic [PC_W-1:0] ext;
		ext = {{(PC_W-DISP_W){disp[DISP_W-1]}}, disp};            // RL2
		return PC_W'(base + ext);                                 // RL1
	endfunction : rel_target

	// Pin-level feedbacks cross into the clock domain here
	logic [PIN_N-1:0] pins_raw;
	logic [PIN_N-1:0] pins_meta_q;
	logic [PIN_N-1:0] pins_q;

	assign pins_raw = {own_current_fb, current_fb, boost_voltage_high,
	                   shortcut_source_fb, shortcut_drain_fb, start_in,
	                   lo_drv_drain_fb, hi_drv_source_fb, hi_drv_drain_fb};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pins_meta_q <= '0;
			pins_q      <= '0;
		end else begin
			pins_meta_q <= pins_raw;
			pins_q      <= pins_meta_q;
		end
	end

	logic                 s_own_cur;
	logic [CUR_N-1:0]     s_cur;
	logic                 s_boost;
	logic [SC_N-1:0]      s_sc_src;
	logic [SC_N-1:0]      s_sc_drain;
	logic                 s_start;
	logic [LO_DRV_N-1:0]  s_lo_drain;
	logic [HI_DRV_N-1:0]  s_hi_src;
	logic [HI_DRV_N-1:0]  s_hi_drain;

	assign {s_own_cur, s_cur, s_boost, s_sc_src, s_sc_drain, s_start,
	        s_lo_drain, s_hi_src, s_hi_drain} = pins_q;

	// Instruction fields
	wire logic [DISP_W-1:0]    disp_field = instr_word[DISP_LSB +: DISP_W];
	wire logic [FBK_SEL_W-1:0] fbk_sel    = instr_word[FBK_SEL_LSB +: FBK_SEL_W]; // RL16
	wire logic                 fbk_pol    = instr_word[FBK_POL_BIT];            // RL16
	wire logic [COND_W-1:0]    cond_code  = instr_word[COND_LSB +: COND_W];
	wire logic                 far_sel    = instr_word[FAR_SEL_BIT];
	wire logic                 cfar_sel   = instr_word[CFAR_SEL_BIT];

	// Opcode decode
	wire logic is_fbkr = instr_word[WORD_W-1:FBKR_LSB] == FBKR_OP;             // RL3
	wire logic is_far  = instr_word[WORD_W-1:FAR_HI_LSB] == FAR_HI_OP
	                   && instr_word[FAR_SEL_BIT-1:0] == FAR_LO_OP;           // RL6
	wire logic is_rel  = instr_word[WORD_W-1:REL_LSB] == REL_OP;               // RL7
	wire logic is_cfar = instr_word[WORD_W-1:CFAR_LSB] == CFAR_HI_OP
	                   && instr_word[CFAR_SEL_BIT-1:0] == CFAR_LO_OP;         // RL8

	logic cond_met;
	logic fbk_met;

	branch_cond_eval u_cond (
		.flags              (flags),
		.terminal_count     (terminal_count),
		.start_level        (s_start),
		.shortcut_drain_fb  (s_sc_drain),
		.shortcut_source_fb (s_sc_src),
		.alu_done           (alu_done),
		.boost_voltage_high (s_boost),
		.current_fb         (s_cur),
		.own_current_fb     (s_own_cur),
		.hi_drv_drain_fb    (s_hi_drain),
		.hi_drv_source_fb   (s_hi_src),
		.lo_drv_drain_fb    (s_lo_drain),
		.cond_code          (cond_code),
		.feedback_selector  (fbk_sel),
		.feedback_polarity  (fbk_pol),
		.cond_met           (cond_met),
		.fbk_met            (fbk_met)
	);

	// Target selection
	wire logic [PC_W-1:0] seq_pc  = PC_W'(instr_addr + PC_STEP);             // RL15
	wire logic [PC_W-1:0] rel_pc  = rel_target(instr_addr, disp_field);      // RL1
	wire logic [PC_W-1:0] far_pc  = jump_register_set[far_sel];              // RL9
	wire logic [PC_W-1:0] cfar_pc = jump_register_set[cfar_sel];             // RL9

	wire logic take_fbkr = is_fbkr && fbk_met;                              // RL3
	wire logic take_cfar = is_cfar && cond_met;                             // RL8
	wire logic taken     = take_fbkr || is_rel || is_far || take_cfar;      // RL6 RL7

	branch_kind_t kind_d;
	logic [PC_W-1:0] pc_d;

	always_comb begin
		kind_d = BR_NONE;
		pc_d   = seq_pc;                                                    // RL15
		if (is_fbkr) begin
			kind_d = BR_FBK_REL;
			if (take_fbkr)
				pc_d = rel_pc;
		end else if (is_far) begin
			kind_d = BR_FAR;
			pc_d   = far_pc;                                                // RL6
		end else if (is_rel) begin
			kind_d = BR_REL;
			pc_d   = rel_pc;                                                // RL7
		end else if (is_cfar) begin
			kind_d = BR_COND_FAR;
			if (take_cfar)
				pc_d = cfar_pc;                                             // RL8
		end
	end

	logic [PC_W-1:0] program_counter_q;
	logic            pc_valid_q;
	logic            branch_taken_q;
	branch_kind_t    branch_kind_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			program_counter_q <= '0;
			pc_valid_q        <= 1'b0;
			branch_taken_q    <= 1'b0;
			branch_kind_q     <= BR_NONE;
		end else begin
			pc_valid_q <= instr_valid;
			if (instr_valid) begin
				program_counter_q <= pc_d;
				branch_taken_q    <= taken;
				branch_kind_q     <= kind_d;
			end
		end
	end

	assign program_counter = program_counter_q;
	assign pc_valid        = pc_valid_q;
	assign branch_taken    = branch_taken_q;
	assign branch_kind     = branch_kind_q;

endmodule : microcore_branch_decode

`default_nettype wire

// ### tb/branch_decode_properties.sv
`timescale 1ns/100ps
`default_nettype none
module branch_decode_checker
	import branch_pkg::*;
#(
	parameter int PC_W = PC_W_DEF
)(
	input wire logic                           clk,
	input wire logic                           rst_n,
	input wire logic                           instr_valid,
	input wire logic [WORD_W-1:0]              instr_word,
	input wire logic [PC_W-1:0]                instr_addr,
	input wire logic [JUMP_REGS-1:0][PC_W-1:0] jump_register_set,
	input wire logic [PC_W-1:0]                program_counter,
	input wire logic                           pc_valid,
	input wire logic                           branch_taken,
	input wire branch_kind_t                   branch_kind,
	input wire logic [FLAG_N-1:0]              flags,
	input wire logic [TC_N-1:0]                terminal_count
);
	wire            is_rel  = instr_valid && instr_word[15:5] == REL_OP;
	wire            is_far  = instr_valid && instr_word[15:4] == FAR_HI_OP && instr_word[2:0] == FAR_LO_OP;
	wire            is_cfar = instr_valid && instr_word[15:11] == CFAR_HI_OP && instr_word[3:0] == CFAR_LO_OP;
	wire            is_fbk  = instr_valid && instr_word[15:10] == FBKR_OP;
	wire [PC_W-1:0] rel_t   = instr_addr + {{(PC_W-DISP_W){instr_word[4]}}, instr_word[4:0]};
	wire [PC_W-1:0] far_t   = jump_register_set[instr_word[FAR_SEL_BIT]];
	wire [PC_W-1:0] cfar_t  = jump_register_set[instr_word[CFAR_SEL_BIT]];
	wire [PC_W-1:0] seq_t   = instr_addr + PC_W'(PC_STEP);
	// Flag and terminal count codes read same-clock inputs, so the outcome is known here
	wire            is_cclk = is_cfar && (!instr_word[10] || instr_word[10:7] == 4'h8);
	wire            clk_hit = instr_word[10] ? terminal_count[instr_word[6:5]] : flags[instr_word[8:5]] == instr_word[9];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_accept_then_miss; instr_valid ##1 !branch_taken; endsequence
	property p_pulse; instr_valid |=> pc_valid; endproperty
	property p_quiet; !instr_valid |=> !pc_valid; endproperty
	property p_hold;
		!instr_valid |=> $stable(program_counter) && $stable(branch_kind) && $stable(branch_taken);
	endproperty
	property p_cclk; is_cclk |=> branch_taken == $past(clk_hit); endproperty
	property p_rel; is_rel |=> branch_taken && branch_kind == BR_REL && program_counter == $past(rel_t); endproperty
	property p_far; is_far |=> branch_taken && branch_kind == BR_FAR && program_counter == $past(far_t); endproperty
	property p_cfar;
		is_cfar |=> branch_kind == BR_COND_FAR && program_counter == (branch_taken ? $past(cfar_t) : $past(seq_t));
	endproperty
	property p_fbk;
		is_fbk |=> branch_kind == BR_FBK_REL && program_counter == (branch_taken ? $past(rel_t) : $past(seq_t));
	endproperty
	property p_step; s_accept_then_miss |-> program_counter == $past(instr_addr) + PC_W'(PC_STEP); endproperty
	a_pulse: assert property (p_pulse) else $error("no pc_valid after accept");
	a_quiet: assert property (p_quiet) else $error("pc_valid without accept");
	a_hold: assert property (p_hold) else $error("outputs moved without accept");
	a_rel: assert property (p_rel) else $error("bad relative jump");
	a_far: assert property (p_far) else $error("bad far jump");
	a_cfar: assert property (p_cfar) else $error("bad conditional far jump");
	a_fbk: assert property (p_fbk) else $error("bad feedback jump");
	a_step: assert property (p_step) else $error("bad sequential step");
	a_cclk: assert property (p_cclk) else $error("flag or terminal count condition misjudged");
endmodule : branch_decode_checker
bind microcore_branch_decode branch_decode_checker #(.PC_W(PC_W)) u_branch_decode_checker (.clk(clk), .rst_n(rst_n),
	.instr_valid(instr_valid), .instr_word(instr_word), .instr_addr(instr_addr), .jump_register_set(jump_register_set),
	.program_counter(program_counter), .pc_valid(pc_valid), .branch_taken(branch_taken), .branch_kind(branch_kind),
	.flags(flags), .terminal_count(terminal_count));
`default_nettype wire

// ### tb/code_memory_model.sv
`timescale 1ns/100ps
`default_nettype none
module code_memory_model
	import branch_pkg::*;
#(
	parameter int PC_W = PC_W_DEF
)(
	input  wire logic              clk,
	input  wire logic              wr_en,
	input  wire logic [PC_W-1:0]   addr,
	input  wire logic [WORD_W-1:0] wr_word,
	output logic      [WORD_W-1:0] word
);
	// Unwritten locations read as unknown
	logic [WORD_W-1:0] mem_q [2**PC_W];
	assign word = mem_q[addr];
	always_ff @(posedge clk) begin
		if (wr_en) mem_q[addr] <= wr_word;
	end
endmodule : code_memory_model
`default_nettype wire

// ### tb/tb_microcore_branch_decode.sv
`timescale 1ns/100ps
`default_nettype none
module tb_microcore_branch_decode
	import branch_pkg::*;
;
	localparam int PC_W = PC_W_DEF;
	logic clk = 0, rst_n = 0, iv = 0, wr_en = 0, alu = 0, st = 0, vb = 0, own = 0, pv, tk;
	logic [WORD_W-1:0] wr_word = '0, iw;
	logic [PC_W-1:0] ia = '0, pc;
	logic [JUMP_REGS-1:0][PC_W-1:0] jr = {10'h15A, 10'h2A5};
	logic [FLAG_N-1:0] fl = '0;
	logic [TC_N-1:0] tc = '0;
	logic [SC_N-1:0] scd = '0, scs = '0;
	logic [CUR_N-1:0] cur = '0;
	logic [HI_DRV_N-1:0] hid = '0, his = '0;
	logic [LO_DRV_N-1:0] lod = '0;
	branch_kind_t kd;
	int n_errors = 0, total_checks = 0, cyc = 0;
	always #4 clk = ~clk;
	code_memory_model #(.PC_W(PC_W)) u_code_memory_model (.clk(clk), .wr_en(wr_en), .addr(ia), .wr_word(wr_word),
		.word(iw));
	microcore_branch_decode #(.PC_W(PC_W)) u_microcore_branch_decode (.clk(clk), .rst_n(rst_n), .instr_valid(iv),
		.instr_word(iw), .instr_addr(ia), .jump_register_set(jr), .flags(fl), .terminal_count(tc), .alu_done(alu),
		.start_in(st), .shortcut_drain_fb(scd), .shortcut_source_fb(scs), .boost_voltage_high(vb), .current_fb(cur),
		.own_current_fb(own), .hi_drv_drain_fb(hid), .hi_drv_source_fb(his), .lo_drv_drain_fb(lod),
		.program_counter(pc), .pc_valid(pv), .branch_taken(tk), .branch_kind(kd));
	task print_verdict;
		if (n_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			print_verdict();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Pins settle through the synchronisers before the word is accepted
	task issue(input logic [15:0] w, input logic [PC_W-1:0] a, input logic [PC_W-1:0] e_pc, input logic e_tk,
		input branch_kind_t e_k);
		repeat (2) @(negedge clk);
		wr_en = 1;
		ia = a;
		wr_word = w;
		@(negedge clk) wr_en = 0;
		iv = 1;
		@(negedge clk) iv = 0;
		chk(pv, 1);
		chk(pc, e_pc);
		chk(tk, e_tk);
		chk(kd, e_k);
		@(negedge clk) chk(pv, 0);
	endtask : issue
	task t_rel;
		logic [4:0] d;
		for (int i = 0; i < 4; i++) begin
			d = i[1] ? (i[0] ? 5'h1F : 5'h00) : (i[0] ? 5'h10 : 5'h0F);
			issue({REL_OP, d}, 10'h005, 10'h005 + {{5{d[4]}}, d}, 1, BR_REL);
		end
	endtask : t_rel
	task t_far;
		for (int r = 0; r < 2; r++) issue({FAR_HI_OP, r[0], FAR_LO_OP}, 10'h030, jr[r], 1, BR_FAR);
	endtask : t_far
	// Reset in mid-run must clear outputs that a far jump left standing
	task t_reset;
		@(negedge clk) rst_n = 0;
		repeat (3) @(negedge clk);
		rst_n = 1;
		chk({pc, pv, tk, kd}, '0);
	endtask : t_reset
	task t_fbk;
		for (int s = 0; s < 16; s++) for (int v = 0; v < 2; v++) for (int p = 0; p < 2; p++) begin
			{hid, his, lod} = '0;
			if (s >= 10) lod[s-10] = v[0];
			else if (s[0]) his[s/2] = v[0];
			else hid[s/2] = v[0];
			issue({FBKR_OP, p[0], s[3:0], 5'h03}, 10'h100, v == p ? 10'h103 : 10'h101, v == p, BR_FBK_REL);
		end
	endtask : t_fbk
	task t_cond;
		logic e;
		for (int c = 0; c < 64; c++) for (int v = 0; v < 2; v++) begin
			{fl, tc, st, scd, scs, alu, vb, cur, own} = '0;
			if (c < 32) fl[c%16] = v[0];
			else if (c < 36) tc[c-32] = v[0];
			else if (c < 38) st = v[0];
			else if (c < 41) scd[c-38] = v[0];
			else if (c < 44) scs[c-41] = v[0];
			else if (c < 47) scd[c-44] = v[0];
			else if (c == 47) alu = v[0];
			else if (c < 50) vb = v[0];
			else if (c < 62) cur[(c-50)%6] = v[0];
			else own = v[0];
			e = v[0] == ((c >= 16 && c <= 35) || c == 37 || (c >= 44 && c <= 48) || (c >= 50 && c <= 55) || c == 62);
			issue({CFAR_HI_OP, c[5:0], c[0], CFAR_LO_OP}, 10'h200, e ? jr[c[0]] : 10'h201, e, BR_COND_FAR);
		end
	endtask : t_cond
	initial begin
		repeat (6) @(negedge clk);
		rst_n = 1;
		chk({pc, pv, tk, kd}, '0);
		t_rel();
		t_far();
		t_reset();
		t_fbk();
		t_cond();
		issue(16'hFFFF, 10'h3FF, 10'h000, 0, BR_NONE);
		print_verdict();
	end
endmodule : tb_microcore_branch_decode
`default_nettype wire
